// >>> rtl/btb_params.svh
// constants for the bit-test branch and cpu control execution block
`ifndef BTB_PARAMS_SVH
`define BTB_PARAMS_SVH
// instruction lengths in bytes
`define BTB_LEN_2 3'h2
`define BTB_LEN_3 3'h3
`define BTB_LEN_4 3'h4
// branch_if_bit_set counts: _hs internal high-speed ram, _ot other area
`define BTB_CYC_BT_SADDR_HS 8'h08
`define BTB_CYC_BT_SADDR_OT 8'h09
`define BTB_CYC_BT_SFR 8'h0b
`define BTB_CYC_BT_ABIT 8'h08
`define BTB_CYC_BT_PSW 8'h09
`define BTB_CYC_BT_HL_HS 8'h0a
`define BTB_CYC_BT_HL_OT 8'h0b
// branch_if_bit_clear counts
`define BTB_CYC_BF_SADDR_HS 8'h0a
`define BTB_CYC_BF_SADDR_OT 8'h0b
`define BTB_CYC_BF_SFR 8'h0b
`define BTB_CYC_BF_ABIT 8'h08
`define BTB_CYC_BF_PSW 8'h0b
`define BTB_CYC_BF_HL_HS 8'h0a
`define BTB_CYC_BF_HL_OT 8'h0b
// branch_set_then_clear counts
`define BTB_CYC_BC_SADDR_HS 8'h0a
`define BTB_CYC_BC_SADDR_OT 8'h0c
`define BTB_CYC_BC_SFR 8'h0c
`define BTB_CYC_BC_ABIT 8'h08
`define BTB_CYC_BC_PSW 8'h0c
`define BTB_CYC_BC_HL_HS 8'h0a
`define BTB_CYC_BC_HL_OT 8'h0c
// decrement_branch_nonzero counts
`define BTB_CYC_DB_REG 8'h06
`define BTB_CYC_DB_SADDR_HS 8'h08
`define BTB_CYC_DB_SADDR_OT 8'h0a
// interrupt enable and disable
`define BTB_CYC_IE 8'h06
// an illegal combination is retired after this many cycles
`define BTB_CYC_ILLEGAL 8'h02
// extra cycles per byte when not fetching from internal program rom
`define BTB_EXT_FETCH_WAIT 8'h00
// reset values
`define BTB_IE_RST 1'b0
`define BTB_PC_RST 16'h0000
`define BTB_DATA_RST 8'h00
`define BTB_CNT_RST 8'h00
`endif

// >>> rtl/btb_pkg.sv
// types shared by the bit-test branch execution block
package btb_pkg;
  typedef enum logic [2:0] {
    BTB_OP_BIT_SET = 3'h0,   // branch_if_bit_set
    BTB_OP_BIT_CLR = 3'h1,   // branch_if_bit_clear
    BTB_OP_SET_CLR = 3'h2,   // branch_set_then_clear
    BTB_OP_DEC_BNZ = 3'h3,   // decrement_branch_nonzero
    BTB_OP_INT_EN = 3'h4,    // interrupt_enable_instr
    BTB_OP_INT_DIS = 3'h5    // interrupt_disable_instr
  } btb_op_t;

  typedef enum logic [2:0] {
    BTB_MD_SADDR = 3'h0,
    BTB_MD_SFR = 3'h1,
    BTB_MD_ABIT = 3'h2,
    BTB_MD_PSW = 3'h3,
    BTB_MD_HL = 3'h4,
    BTB_MD_REG_B = 3'h5,
    BTB_MD_REG_C = 3'h6,
    BTB_MD_NONE = 3'h7
  } btb_mode_t;

  // classes of 8-bit operations offered to the group check
  typedef enum logic [3:0] {
    BTB_G8_MOVE = 4'h0,
    BTB_G8_XCHG = 4'h1,
    BTB_G8_ADD = 4'h2,      // add and add_with_carry
    BTB_G8_SUB = 4'h3,      // sub and subtract_with_borrow
    BTB_G8_LOGIC = 4'h4,
    BTB_G8_CMP = 4'h5,
    BTB_G8_UNSIGNED_MULTIPLY = 4'h6,     // unsigned_multiply
    BTB_G8_DIVW = 4'h7,     // unsigned_word_divide
    BTB_G8_INCDEC = 4'h8,
    BTB_G8_ROT = 4'h9,      // rotates incl. through carry
    BTB_G8_ROT4 = 4'ha,     // nibble rotates
    BTB_G8_STACK = 4'hb,
    BTB_G8_DECREMENT_BRANCH_NONZERO = 4'hc,
    BTB_G8_OTHER = 4'hf
  } btb_grp8_t;

  // gray coded along idle -> run -> idle
  typedef enum logic [0:0] {
    BTB_IDLE = 1'b0,
    BTB_RUN = 1'b1
  } btb_state_t;

  typedef struct packed {
    btb_state_t state;
    logic busy;
    logic done;
    logic taken;
    logic [15:0] pc;
    logic wr_req;
    logic wr_en;
    logic [7:0] wr_data;
    logic flag_chg;
    logic ie_upd;
    logic ie_val;
    logic ie;
    logic illegal;
    logic [7:0] cycles;
    logic [2:0] len;
    logic nominal;
    logic grp8;
  } btb_regs_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic expire;
  } btb_tmr_t;
endpackage

// >>> rtl/btb_cycle_timer.sv
// down counter that pulses once a loaded cycle count has elapsed
`timescale 1ns/1ps
`include "btb_params.svh"
module btb_cycle_timer (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic load_i,
  input wire logic [7:0] count_i,
  output logic expire_o
);
  import btb_pkg::*;

  btb_tmr_t r;
  btb_tmr_t n;

  // count down, pulse on the step from one to zero
  always_comb begin
    n = r;
    n.expire = 1'b0;
    if (load_i) begin
      n.cnt = count_i;
    end else if (r.cnt != `BTB_CNT_RST) begin
      n.cnt = r.cnt - 8'h01;
      n.expire = (r.cnt == 8'h01);
    end
  end

  // frozen while the processor clock tick is absent
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      r <= '{cnt: `BTB_CNT_RST, expire: 1'b0};
    end else if (clk_en_i) begin
      r <= n;
    end
  end

  assign expire_o = r.expire;
endmodule

// >>> rtl/btb_exec.sv
// execution of bit-test branches, decrement branch and interrupt control
//
// What this block does
// [RULE1] bit-set branch on accumulator bit: pc+3+disp if one; 3B, 8 cycles
// [RULE2] bit-set branch on sfr bit: 4 bytes, 11 cycles, pc+4+disp if one
// [RULE3] bit-set branch on pointer-pair bit: 3 bytes, 10/11 cycles, pc+3+disp
// [RULE4] bit-clear branch on sfr bit: pc+4+disp when zero, else fall through
// [RULE5] bit-clear branch on short-direct bit: 4 bytes, 10/11 cycles, pc+4
// [RULE6] set-then-clear branch: branch on one and clear bit; pointer form 3B
// [RULE7] set-then-clear on status word bit may change z, ac, carry; 4B, 12cyc
// [RULE8] decrement branch on b or c: subtract one, pc+2+disp if nonzero; 6cyc
// [RULE9] decrement branch on short-direct byte: write back, pc+3; 8/10 cycles
// [RULE10] interrupt enable sets master enable; 2 bytes, 6 cycles
// [RULE11] interrupt disable clears master enable; 2 bytes, 6 cycles
// [RULE12] all cycle counts are counted in processor clock periods
// [RULE13] longer count applies when the area is not high-speed ram
// [RULE14] listed counts hold for fetches from internal program rom
// [RULE15] 8-bit group: moves, arithmetic, logic, multiply, divide, rotates
// [RULE16] displacement is signed and sign-extended to 16 bits
`timescale 1ns/1ps
`include "btb_params.svh"
module btb_exec #(
  parameter logic [7:0] EXT_FETCH_WAIT = `BTB_EXT_FETCH_WAIT
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire btb_pkg::btb_op_t op_i,
  input wire btb_pkg::btb_mode_t mode_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] operand_i,
  input wire logic [7:0] disp_i,
  input wire logic [15:0] pc_i,
  input wire logic hsram_i,
  input wire logic rom_fetch_i,
  input wire btb_pkg::btb_grp8_t grp8_class_i,
  output logic busy_o,
  output logic done_o,
  output logic taken_o,
  output logic [15:0] pc_o,
  output logic wr_en_o,
  output logic [7:0] wr_data_o,
  output logic flag_chg_o,
  output logic master_interrupt_enable_o,
  output logic illegal_o,
  output logic [7:0] cycles_o,
  output logic [2:0] len_o,
  output logic nominal_o,
  output logic grp8_o
);
  import btb_pkg::*;

  btb_regs_t r;
  btb_regs_t n;
  logic tmr_load;
  logic [7:0] tmr_val;
  logic tmr_expire;
  logic legal;
  logic [2:0] len;
  logic [7:0] cyc_hs;
  logic [7:0] cyc_ot;
  logic [7:0] cyc;
  logic tbit;
  logic [7:0] dec;
  logic [7:0] cleared;
  logic [15:0] disp16;
  logic [15:0] pc_seq;
  logic [15:0] pc_tgt;
  logic taken;
  logic wr_req;
  logic [7:0] wr_data;
  logic flag_chg;
  logic is_grp8;

  // length and both cycle counts per instruction form
  always_comb begin
    legal = 1'b1;
    len = `BTB_LEN_3;
    cyc_hs = `BTB_CYC_ILLEGAL;
    cyc_ot = `BTB_CYC_ILLEGAL;
    case (op_i)
      BTB_OP_BIT_SET: begin
        case (mode_i)
          BTB_MD_SADDR: begin
            cyc_hs = `BTB_CYC_BT_SADDR_HS;
            cyc_ot = `BTB_CYC_BT_SADDR_OT;
          end
          BTB_MD_SFR: begin
            len = `BTB_LEN_4; // see [RULE2]
            cyc_hs = `BTB_CYC_BT_SFR; // see [RULE2]
            cyc_ot = `BTB_CYC_BT_SFR;
          end
          BTB_MD_ABIT: begin
            cyc_hs = `BTB_CYC_BT_ABIT; // see [RULE1]
            cyc_ot = `BTB_CYC_BT_ABIT;
          end
          BTB_MD_PSW: begin
            cyc_hs = `BTB_CYC_BT_PSW;
            cyc_ot = `BTB_CYC_BT_PSW;
          end
          BTB_MD_HL: begin
            cyc_hs = `BTB_CYC_BT_HL_HS; // see [RULE3]
            cyc_ot = `BTB_CYC_BT_HL_OT;
          end
          default: legal = 1'b0;
        endcase
      end
      BTB_OP_BIT_CLR: begin
        case (mode_i)
          BTB_MD_SADDR: begin
            len = `BTB_LEN_4; // see [RULE5]
            cyc_hs = `BTB_CYC_BF_SADDR_HS; // see [RULE5]
            cyc_ot = `BTB_CYC_BF_SADDR_OT;
          end
          BTB_MD_SFR: begin
            len = `BTB_LEN_4; // see [RULE4]
            cyc_hs = `BTB_CYC_BF_SFR;
            cyc_ot = `BTB_CYC_BF_SFR;
          end
          BTB_MD_ABIT: begin
            cyc_hs = `BTB_CYC_BF_ABIT;
            cyc_ot = `BTB_CYC_BF_ABIT;
          end
          BTB_MD_PSW: begin
            len = `BTB_LEN_4;
            cyc_hs = `BTB_CYC_BF_PSW;
            cyc_ot = `BTB_CYC_BF_PSW;
          end
          BTB_MD_HL: begin
            cyc_hs = `BTB_CYC_BF_HL_HS;
            cyc_ot = `BTB_CYC_BF_HL_OT;
          end
          default: legal = 1'b0;
        endcase
      end
      BTB_OP_SET_CLR: begin
        case (mode_i)
          BTB_MD_SADDR: begin
            len = `BTB_LEN_4;
            cyc_hs = `BTB_CYC_BC_SADDR_HS;
            cyc_ot = `BTB_CYC_BC_SADDR_OT;
          end
          BTB_MD_SFR: begin
            len = `BTB_LEN_4;
            cyc_hs = `BTB_CYC_BC_SFR;
            cyc_ot = `BTB_CYC_BC_SFR;
          end
          BTB_MD_ABIT: begin
            cyc_hs = `BTB_CYC_BC_ABIT;
            cyc_ot = `BTB_CYC_BC_ABIT;
          end
          BTB_MD_PSW: begin
            len = `BTB_LEN_4; // see [RULE7]
            cyc_hs = `BTB_CYC_BC_PSW; // see [RULE7]
            cyc_ot = `BTB_CYC_BC_PSW;
          end
          BTB_MD_HL: begin
            cyc_hs = `BTB_CYC_BC_HL_HS; // see [RULE6]
            cyc_ot = `BTB_CYC_BC_HL_OT; // see [RULE6]
          end
          default: legal = 1'b0;
        endcase
      end
      BTB_OP_DEC_BNZ: begin
        case (mode_i)
          BTB_MD_REG_B, BTB_MD_REG_C: begin
            len = `BTB_LEN_2; // see [RULE8]
            cyc_hs = `BTB_CYC_DB_REG; // see [RULE8]
            cyc_ot = `BTB_CYC_DB_REG;
          end
          BTB_MD_SADDR: begin
            cyc_hs = `BTB_CYC_DB_SADDR_HS; // see [RULE9]
            cyc_ot = `BTB_CYC_DB_SADDR_OT; // see [RULE9]
          end
          default: legal = 1'b0;
        endcase
      end
      BTB_OP_INT_EN, BTB_OP_INT_DIS: begin
        len = `BTB_LEN_2; // see [RULE10] [RULE11]
        cyc_hs = `BTB_CYC_IE; // see [RULE10] [RULE11]
        cyc_ot = `BTB_CYC_IE;
      end
      default: legal = 1'b0;
    endcase
  end

  // count selection and the data path of the tested operand
  always_comb begin
    cyc = hsram_i ? cyc_hs : cyc_ot; // see [RULE13]
    // counts grow only for fetches outside internal rom
    if (!rom_fetch_i && legal) begin
      cyc = cyc + 8'({5'h00, len} * EXT_FETCH_WAIT); // see [RULE14]
    end
    tbit = operand_i[bit_sel_i];
    dec = operand_i - 8'h01; // see [RULE8] [RULE9]
    cleared = operand_i & ~(8'h01 << bit_sel_i); // see [RULE6]
    disp16 = {{8{disp_i[7]}}, disp_i}; // see [RULE16]
    pc_seq = pc_i + {13'h0000, len};
    pc_tgt = pc_seq + disp16; // see [RULE1] [RULE2] [RULE3]
    taken = 1'b0;
    wr_req = 1'b0;
    wr_data = operand_i;
    flag_chg = 1'b0;
    case (op_i)
      BTB_OP_BIT_SET: taken = tbit; // see [RULE1] [RULE2] [RULE3]
      BTB_OP_BIT_CLR: taken = ~tbit; // see [RULE4] [RULE5]
      BTB_OP_SET_CLR: begin
        taken = tbit; // see [RULE6]
        wr_req = tbit; // see [RULE6]
        wr_data = cleared;
        flag_chg = tbit && (mode_i == BTB_MD_PSW); // see [RULE7]
      end
      BTB_OP_DEC_BNZ: begin
        wr_req = 1'b1; // see [RULE9]
        wr_data = dec;
        taken = (dec != 8'h00); // see [RULE8] [RULE9]
      end
      default: taken = 1'b0;
    endcase
    taken = taken && legal;
    wr_req = wr_req && legal;
    flag_chg = flag_chg && legal;
  end

  // membership in the 8-bit instruction group
  always_comb begin
    case (grp8_class_i)
      BTB_G8_OTHER: is_grp8 = 1'b0;
      default: is_grp8 = 1'b1; // see [RULE15]
    endcase
  end

  // sequencing: take a request, hold busy for the count, retire
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.wr_en = 1'b0;
    tmr_load = 1'b0;
    tmr_val = 8'h00;
    case (r.state)
      BTB_IDLE: begin
        if (start_i) begin
          n.state = BTB_RUN;
          n.busy = 1'b1;
          n.illegal = ~legal;
          n.len = len;
          n.cycles = cyc;
          n.nominal = rom_fetch_i; // see [RULE14]
          n.grp8 = is_grp8;
          n.taken = taken;
          n.pc = taken ? pc_tgt : pc_seq;
          n.wr_req = wr_req;
          n.wr_data = wr_data;
          n.flag_chg = flag_chg;
          n.ie_upd = legal && (op_i == BTB_OP_INT_EN ||
                               op_i == BTB_OP_INT_DIS);
          n.ie_val = (op_i == BTB_OP_INT_EN);
          tmr_load = 1'b1;
          // the taking cycle is the first of the count
          tmr_val = cyc - 8'h01;
        end
      end
      BTB_RUN: begin
        if (tmr_expire) begin
          n.state = BTB_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.wr_en = r.wr_req; // see [RULE6] [RULE9]
          if (r.ie_upd) begin
            n.ie = r.ie_val; // see [RULE10] [RULE11]
          end
        end
      end
      default: begin
        n.state = BTB_IDLE;
        n.busy = 1'b0;
      end
    endcase
  end

  // state advances only on processor clock ticks
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      r <= '{state: BTB_IDLE, busy: 1'b0, done: 1'b0, taken: 1'b0,
             pc: `BTB_PC_RST, wr_req: 1'b0, wr_en: 1'b0,
             wr_data: `BTB_DATA_RST, flag_chg: 1'b0, ie_upd: 1'b0,
             ie_val: 1'b0, ie: `BTB_IE_RST, illegal: 1'b0,
             cycles: `BTB_CNT_RST, len: 3'h0, nominal: 1'b0,
             grp8: 1'b0};
    end else if (clk_en_i) begin
      r <= n; // see [RULE12]
    end
  end

  btb_cycle_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .load_i(tmr_load),
    .count_i(tmr_val),
    .expire_o(tmr_expire)
  );

  // every output is a field of the state register
  assign busy_o = r.busy;
  assign done_o = r.done;
  assign taken_o = r.taken;
  assign pc_o = r.pc;
  assign wr_en_o = r.wr_en;
  assign wr_data_o = r.wr_data;
  assign flag_chg_o = r.flag_chg;
  assign master_interrupt_enable_o = r.ie;
  assign illegal_o = r.illegal;
  assign cycles_o = r.cycles;
  assign len_o = r.len;
  assign nominal_o = r.nominal;
  assign grp8_o = r.grp8;
endmodule

// >>> testbench/btb_data_mem.sv
// data memory byte: feeds the tested operand and takes write-backs
`timescale 1ns/1ps
module btb_data_mem (
  input wire logic clk_sys_i,
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem_ff;
  // preload wins; a write-back lands one edge after retire
  always_ff @(posedge clk_sys_i) begin
    if (load_i) begin
      mem_ff <= load_val_i;
    end else if (wr_en_i) begin
      mem_ff <= wr_data_i;
    end
  end
  assign rd_data_o = mem_ff;
endmodule

// >>> testbench/btb_exec_checker.sv
// assertion checker on the execution block ports
`timescale 1ns/1ps
module btb_exec_checker #(
  parameter logic [7:0] EXT_FETCH_WAIT = 8'h00
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  input wire btb_pkg::btb_op_t op_i,
  input wire btb_pkg::btb_mode_t mode_i,
  input wire logic rom_fetch_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic taken_o,
  input wire logic wr_en_o,
  input wire logic master_interrupt_enable_o,
  input wire logic illegal_o,
  input wire logic [7:0] cycles_o,
  input wire logic [2:0] len_o
);
  import btb_pkg::*;
  logic [7:0] cnt_ff;
  btb_op_t op_ff;
  // ticks since take; frozen with clk_en low, as the block is
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cnt_ff <= 8'h00;
      op_ff <= BTB_OP_BIT_SET;
    end else if (clk_en_i && start_i && !busy_o) begin
      cnt_ff <= 8'h00;
      op_ff <= op_i;
    end else if (clk_en_i && busy_o) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence s_take; clk_en_i && start_i && !busy_o; endsequence
  sequence s_retire; done_o && !busy_o; endsequence
  property p_busy; s_take |=> busy_o && !done_o; endproperty
  a_busy: assert property (p_busy)
    else $error("no busy after take");
  property p_count; s_retire |-> illegal_o || cnt_ff == cycles_o; endproperty
  a_count: assert property (p_count)
    else $error("retire tick count differs from cycle count");
  property p_wr; wr_en_o |-> s_retire; endproperty
  a_wr: assert property (p_wr)
    else $error("write-back outside retire");
  property p_clear;
    done_o && op_ff == BTB_OP_SET_CLR |-> wr_en_o == taken_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear write does not follow branch");
  property p_ie_on;
    done_o && op_ff == BTB_OP_INT_EN |-> master_interrupt_enable_o;
  endproperty
  a_ie_on: assert property (p_ie_on)
    else $error("enable not set at retire");
  property p_ie_off;
    done_o && op_ff == BTB_OP_INT_DIS |-> !master_interrupt_enable_o;
  endproperty
  a_ie_off: assert property (p_ie_off)
    else $error("enable not cleared at retire");
  property p_abit;
    s_take ##0 (op_i == BTB_OP_BIT_SET && mode_i == BTB_MD_ABIT && rom_fetch_i)
      |=> len_o == 3'h3 && cycles_o == 8'h08;
  endproperty
  a_abit: assert property (p_abit)
    else $error("accumulator bit test length or count wrong");
  property p_decrement_branch_nonzero;
    s_take ##0 (op_i == BTB_OP_DEC_BNZ && mode_i == BTB_MD_REG_C
      && rom_fetch_i) |=> len_o == 3'h2 && cycles_o == 8'h06;
  endproperty
  a_decrement_branch_nonzero: assert property (p_decrement_branch_nonzero)
    else $error("register decrement length or count wrong");
  property p_ext;
    s_take ##0 (op_i == BTB_OP_BIT_SET && mode_i == BTB_MD_ABIT
      && !rom_fetch_i) |=> cycles_o == 8'h08 + EXT_FETCH_WAIT * 8'h03;
  endproperty
  a_ext: assert property (p_ext)
    else $error("non-rom fetch count wrong");
endmodule

bind btb_exec btb_exec_checker #(.EXT_FETCH_WAIT(EXT_FETCH_WAIT)) u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
  .start_i(start_i), .op_i(op_i), .mode_i(mode_i),
  .rom_fetch_i(rom_fetch_i), .busy_o(busy_o), .done_o(done_o),
  .taken_o(taken_o), .wr_en_o(wr_en_o),
  .master_interrupt_enable_o(master_interrupt_enable_o),
  .illegal_o(illegal_o), .cycles_o(cycles_o), .len_o(len_o));

// >>> testbench/btb_exec_bench.sv
// self-checking bench for the execution block and its data memory
`timescale 1ns/1ps
module btb_exec_bench;
  import btb_pkg::*;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, clk_en_i = 1'b1;
  logic start_i = 1'b0, hsram_i = 1'b1, rom_fetch_i = 1'b1;
  logic ld = 1'b1, slow = 1'b0, wr_seen;
  btb_op_t op_i = BTB_OP_BIT_SET;
  btb_mode_t mode_i = BTB_MD_ABIT;
  btb_grp8_t grp8_class_i = BTB_G8_OTHER;
  logic [2:0] bit_sel_i = 3'h3, len_o;
  logic [7:0] operand_i, disp_i = 8'h00, ldv = 8'h00, wr_data_o, cycles_o;
  logic [15:0] pc_i = 16'h1000, pc_o;
  logic busy_o, done_o, taken_o, wr_en_o, flag_chg_o, illegal_o;
  logic master_interrupt_enable_o, nominal_o, grp8_o;
  int n_fail = 0, num_checks = 0;

  // one extra wait cycle per byte when not fetching from rom
  btb_exec #(.EXT_FETCH_WAIT(8'h01)) dut (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .clk_en_i(clk_en_i), .start_i(start_i),
    .op_i(op_i), .mode_i(mode_i), .bit_sel_i(bit_sel_i),
    .operand_i(operand_i), .disp_i(disp_i), .pc_i(pc_i),
    .hsram_i(hsram_i), .rom_fetch_i(rom_fetch_i),
    .grp8_class_i(grp8_class_i), .busy_o(busy_o), .done_o(done_o),
    .taken_o(taken_o), .pc_o(pc_o), .wr_en_o(wr_en_o),
    .wr_data_o(wr_data_o), .flag_chg_o(flag_chg_o),
    .master_interrupt_enable_o(master_interrupt_enable_o),
    .illegal_o(illegal_o), .cycles_o(cycles_o), .len_o(len_o),
    .nominal_o(nominal_o), .grp8_o(grp8_o));
  btb_data_mem mem (.clk_sys_i(clk_sys_i), .load_i(ld), .load_val_i(ldv),
    .wr_en_i(wr_en_o), .wr_data_i(wr_data_o), .rd_data_o(operand_i));

  // 40 mhz system clock
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // processor tick every edge, or every other edge in slow mode
  always @(posedge clk_sys_i) begin
    clk_en_i <= slow ? ~clk_en_i : 1'b1;
  end

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // preload operand, issue, count ticks to retire, judge the result
  task run(input btb_op_t o, input btb_mode_t m, input logic [7:0] v,
    input logic [7:0] d, input logic h, input logic [7:0] ec,
    input logic [2:0] el, input logic et);
    int k;
    logic [15:0] ep;
    @(posedge clk_sys_i);
    op_i <= o;
    mode_i <= m;
    ld <= 1'b1;
    ldv <= v;
    disp_i <= d;
    hsram_i <= h;
    @(posedge clk_sys_i);
    ld <= 1'b0;
    start_i <= 1'b1;
    @(posedge clk_sys_i);
    if (clk_en_i !== 1'b1) @(posedge clk_sys_i);
    start_i <= 1'b0;
    k = 0;
    #1;
    while (k < 300 && done_o !== 1'b1) begin
      @(posedge clk_sys_i);
      if (clk_en_i === 1'b1) k++;
      #1;
    end
    if (done_o !== 1'b1) begin
      n_fail++;
      tally_and_finish;
    end
    wr_seen = wr_en_o;
    ep = pc_i + 16'(el);
    if (et) ep = ep + {{8{d[7]}}, d};
    chk("ticks", 16'(ec), 16'(k));
    chk("len", 16'(el), 16'(len_o));
    chk("taken", 16'(et), 16'(taken_o));
    chk("next_pc", ep, pc_o);
  endtask

  task t_bitset;
    run(BTB_OP_BIT_SET, BTB_MD_ABIT, 8'h08, 8'hf0,
      1'b1, 8'h08, 3'h3, 1'b1);
    run(BTB_OP_BIT_SET, BTB_MD_SFR, 8'h08, 8'h10,
      1'b0, 8'h0b, 3'h4, 1'b1);
    run(BTB_OP_BIT_SET, BTB_MD_HL, 8'h08, 8'h7f,
      1'b1, 8'h0a, 3'h3, 1'b1);
    run(BTB_OP_BIT_SET, BTB_MD_HL, 8'hf7, 8'h7f,
      1'b0, 8'h0b, 3'h3, 1'b0);
    run(BTB_OP_BIT_SET, BTB_MD_SADDR, 8'h08, 8'h01,
      1'b0, 8'h09, 3'h3, 1'b1);
    run(BTB_OP_BIT_SET, BTB_MD_PSW, 8'hf7, 8'h01,
      1'b1, 8'h09, 3'h3, 1'b0);
  endtask

  task t_bitclr;
    run(BTB_OP_BIT_CLR, BTB_MD_SFR, 8'hf7, 8'h80,
      1'b1, 8'h0b, 3'h4, 1'b1);
    run(BTB_OP_BIT_CLR, BTB_MD_SADDR, 8'h08, 8'h80,
      1'b0, 8'h0b, 3'h4, 1'b0);
    run(BTB_OP_BIT_CLR, BTB_MD_SADDR, 8'hf7, 8'h80,
      1'b1, 8'h0a, 3'h4, 1'b1);
    run(BTB_OP_BIT_CLR, BTB_MD_ABIT, 8'hf7, 8'h02,
      1'b1, 8'h08, 3'h3, 1'b1);
    run(BTB_OP_BIT_CLR, BTB_MD_PSW, 8'h08, 8'h02,
      1'b1, 8'h0b, 3'h4, 1'b0);
    run(BTB_OP_BIT_CLR, BTB_MD_HL, 8'hf7, 8'h02,
      1'b0, 8'h0b, 3'h3, 1'b1);
  endtask

  task t_setclr;
    run(BTB_OP_SET_CLR, BTB_MD_HL, 8'hff, 8'h05,
      1'b0, 8'h0c, 3'h3, 1'b1);
    chk("wr", 16'h0001, 16'(wr_seen));
    @(posedge clk_sys_i);
    #1;
    chk("mem", 16'h00f7, 16'(operand_i));
    run(BTB_OP_SET_CLR, BTB_MD_PSW, 8'h08, 8'h05,
      1'b0, 8'h0c, 3'h4, 1'b1);
    chk("flags", 16'h0001, 16'(flag_chg_o));
    // bit already zero: no branch, no write, no flag change
    run(BTB_OP_SET_CLR, BTB_MD_SFR, 8'hf7, 8'h05,
      1'b1, 8'h0c, 3'h4, 1'b0);
    chk("wr", 16'h0000, 16'(wr_seen));
    chk("flags", 16'h0000, 16'(flag_chg_o));
    run(BTB_OP_SET_CLR, BTB_MD_SADDR, 8'h08, 8'h05,
      1'b1, 8'h0a, 3'h4, 1'b1);
    run(BTB_OP_SET_CLR, BTB_MD_ABIT, 8'h08, 8'h05,
      1'b1, 8'h08, 3'h3, 1'b1);
  endtask

  task t_dec;
    run(BTB_OP_DEC_BNZ, BTB_MD_REG_C, 8'h00, 8'h7f,
      1'b1, 8'h06, 3'h2, 1'b1);
    chk("dec", 16'h00ff, 16'(wr_data_o));
    run(BTB_OP_DEC_BNZ, BTB_MD_SADDR, 8'h01, 8'h7f,
      1'b0, 8'h0a, 3'h3, 1'b0);
    @(posedge clk_sys_i);
    #1;
    chk("mem", 16'h0000, 16'(operand_i));
    run(BTB_OP_DEC_BNZ, BTB_MD_SADDR, 8'h02, 8'h7f,
      1'b1, 8'h08, 3'h3, 1'b1);
    // undefined combination retires after two cycles with no effect
    run(BTB_OP_DEC_BNZ, BTB_MD_ABIT, 8'h02, 8'h7f,
      1'b1, 8'h02, 3'h3, 1'b0);
    chk("illegal", 16'h0001, 16'(illegal_o));
    chk("wr", 16'h0000, 16'(wr_seen));
    run(BTB_OP_DEC_BNZ, BTB_MD_REG_B, 8'h02, 8'h7f,
      1'b1, 8'h06, 3'h2, 1'b1);
    chk("illegal", 16'h0000, 16'(illegal_o));
    chk("dec", 16'h0001, 16'(wr_data_o));
  endtask

  // alternate enable and disable while walking every group class
  task t_int;
    for (int i = 0; i < 14; i++) begin
      @(posedge clk_sys_i);
      grp8_class_i <= (i == 13) ? BTB_G8_OTHER : btb_grp8_t'(i);
      run(i[0] ? BTB_OP_INT_DIS : BTB_OP_INT_EN, BTB_MD_NONE, 8'h00,
        8'h00, 1'b1, 8'h06, 3'h2, 1'b0);
      chk("ie", 16'(!i[0]), 16'(master_interrupt_enable_o));
      chk("grp8", 16'(i != 13), 16'(grp8_o));
    end
  endtask

  // slow processor clock, then a fetch from outside rom
  task t_tick;
    @(posedge clk_sys_i);
    slow <= 1'b1;
    run(BTB_OP_BIT_SET, BTB_MD_ABIT, 8'h08, 8'h02,
      1'b1, 8'h08, 3'h3, 1'b1);
    @(posedge clk_sys_i);
    slow <= 1'b0;
    rom_fetch_i <= 1'b0;
    run(BTB_OP_BIT_SET, BTB_MD_ABIT, 8'h08, 8'h02,
      1'b1, 8'h0b, 3'h3, 1'b1);
    chk("nominal", 16'h0000, 16'(nominal_o));
  endtask

  initial begin
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk("pc_rst", 16'h0000, pc_o);
    chk("ie_rst", 16'h0000, 16'(master_interrupt_enable_o));
    t_bitset;
    t_bitclr;
    t_setclr;
    t_dec;
    t_int;
    t_tick;
    tally_and_finish;
  end
endmodule
